// ==== logic/aks_pkg.sv ====
// Purpose: shared constants and types of the accelerator kernel shell
// Assumes: 32-bit register slave, word-aligned register offsets
// Notes:   register offsets are byte addresses on the register slave
package aks_pkg;

	localparam logic [31:0] AKS_OFF_CTRL   = 32'h0000_0000;
	localparam logic [31:0] AKS_OFF_STATUS = 32'h0000_0004;
	localparam logic [31:0] AKS_OFF_BASE   = 32'h0000_0008;
	localparam logic [31:0] AKS_OFF_LEN    = 32'h0000_000c;
	localparam int          AKS_BIT_START  = 0;
	localparam int          AKS_BIT_ACK    = 0;
	localparam logic [31:0] AKS_BASE_RST   = 32'h0000_0000;
	localparam logic [15:0] AKS_LEN_RST    = 16'h0000;
	localparam logic [1:0]  AKS_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  AKS_RESP_SLVERR = 2'h2;
	localparam logic [1:0]  AKS_BURST_INCR = 2'h1;
	localparam logic [7:0]  AKS_ARLEN_ONE  = 8'h00;
	localparam logic [2:0]  AKS_SYNC_RST   = 3'h0;

	typedef enum logic [1:0] {
		AKS_MODE_SEQ  = 2'h0,
		AKS_MODE_PIPE = 2'h1,
		AKS_MODE_FREE = 2'h2
	} aks_mode_t;

	typedef enum logic [2:0] {
		AKS_ST_IDLE = 3'b001,
		AKS_ST_ADDR = 3'b010,
		AKS_ST_DATA = 3'b100
	} aks_state_t;

	typedef struct packed {
		logic        start;
		logic        ack;
		logic [31:0] base;
		logic [15:0] len;
	} aks_ctrl_t;

	// Packed so that it reads back as the low status bits, done at bit 0
	typedef struct packed {
		aks_mode_t mode;
		logic      sec_alive;
		logic      ready;
		logic      busy;
		logic      done;
	} aks_stat_t;

	function automatic logic aks_hit(input logic [31:0] addr,
		input logic [31:0] off);
		return addr[31:2] == off[31:2];
	endfunction

	function automatic logic [31:0] aks_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

// ==== logic/aks_lite_slave.sv ====
// Purpose: register slave holding start, acknowledge, base and length
// Assumes: one request in flight per channel, master keeps valid high
// Notes:   unmapped offsets answer with a slave error, reads give zero
`timescale 1ns/1ps
module aks_lite_slave (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [31:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [31:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	output aks_pkg::aks_ctrl_t    ctrl,
	input  wire aks_pkg::aks_stat_t stat
);
	import aks_pkg::*;

	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        rvalid_reg;
	logic [1:0]  rresp_reg;
	logic [31:0] rdata_reg;
	logic        start_reg;
	logic        ack_reg;
	logic [31:0] base_reg;
	logic [15:0] len_reg;
	logic [31:0] len_wide;
	logic [31:0] rd_word;
	logic        wr_take;
	logic        rd_take;
	logic        w_ctrl, w_stat, w_base, w_len, w_known;
	logic        r_ctrl, r_stat, r_base, r_len, r_known;

	assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_take = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_take;
	assign s_axi_wready  = wr_take;
	assign s_axi_arready = rd_take;

	assign w_ctrl  = aks_hit(s_axi_awaddr, AKS_OFF_CTRL);
	assign w_stat  = aks_hit(s_axi_awaddr, AKS_OFF_STATUS);
	assign w_base  = aks_hit(s_axi_awaddr, AKS_OFF_BASE);
	assign w_len   = aks_hit(s_axi_awaddr, AKS_OFF_LEN);
	assign w_known = w_ctrl || w_stat || w_base || w_len;
	assign r_ctrl  = aks_hit(s_axi_araddr, AKS_OFF_CTRL);
	assign r_stat  = aks_hit(s_axi_araddr, AKS_OFF_STATUS);
	assign r_base  = aks_hit(s_axi_araddr, AKS_OFF_BASE);
	assign r_len   = aks_hit(s_axi_araddr, AKS_OFF_LEN);
	assign r_known = r_ctrl || r_stat || r_base || r_len;
	assign len_wide = aks_merge({16'h0000, len_reg}, s_axi_wdata,
		s_axi_wstrb);

	// Control register reads as zero: start is a pulse, not a state
	assign rd_word = r_stat ? {26'h0, stat} :
		r_base ? base_reg :
		r_len  ? {16'h0000, len_reg} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= AKS_RESP_OKAY;
			start_reg  <= 1'b0;
			ack_reg    <= 1'b0;
			base_reg   <= AKS_BASE_RST;
			len_reg    <= AKS_LEN_RST;
		end else begin
			start_reg <= wr_take && w_ctrl && s_axi_wstrb[0] &&
				s_axi_wdata[AKS_BIT_START];
			ack_reg <= wr_take && w_stat && s_axi_wstrb[0] &&
				s_axi_wdata[AKS_BIT_ACK];
			if (wr_take) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= w_known ? AKS_RESP_OKAY : AKS_RESP_SLVERR;
				if (w_base) begin
					base_reg <= aks_merge(base_reg, s_axi_wdata,
						s_axi_wstrb);
				end
				if (w_len) begin
					len_reg <= len_wide[15:0];
				end
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= AKS_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= r_known ? AKS_RESP_OKAY : AKS_RESP_SLVERR;
			rdata_reg  <= rd_word;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;
	assign ctrl = '{start: start_reg, ack: ack_reg, base: base_reg,
		len: len_reg};

	property p_resp_hold;
		@(posedge clk) disable iff (!nrst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_resp_hold: assert property (p_resp_hold)
		else $error("write response dropped before taken");

endmodule // aks_lite_slave

// ==== logic/aks_kernel.sv ====
// Purpose: kernel shell with register slave, memory master and streams
// Assumes: memory words and stream beats are DATA_W wide, reads only
// Notes:   read errors from memory are not reported, data passes on
// How it works
// - One execution mode fixed by parameter
// - Sequential: start only when idle, done
// - Pipelined: one queued start, ready notified
// - Free-running: runs from reset, data paced
// - Free-running never drives memory master
// - Host initiates every register access
// - Single register slave port
// - Memory data through master read port
// - Host writes buffer base, master uses it
// - Streams one-way, ordered, unbounded
// - Last flag marks final stream beat
// - Primary clock drives all main logic
// - Optional secondary clock domain port
// - Primary reset low, synchronous, sampled
// - Secondary reset low, its own domain
`timescale 1ns/1ps
module aks_kernel #(
	parameter aks_pkg::aks_mode_t MODE = aks_pkg::AKS_MODE_SEQ,
	parameter int unsigned        DATA_W = 32
) (
	input  wire logic              kernel_primary_clock,
	input  wire logic              kernel_primary_reset_low,
	input  wire logic              kernel_secondary_clock,
	input  wire logic              kernel_secondary_reset_low,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            m_axi_araddr,
	output logic [7:0]             m_axi_arlen,
	output logic [2:0]             m_axi_arsize,
	output logic [1:0]             m_axi_arburst,
	output logic                   m_axi_arvalid,
	input  wire logic              m_axi_arready,
	input  wire logic [DATA_W-1:0] m_axi_rdata,
	input  wire logic [1:0]        m_axi_rresp,
	input  wire logic              m_axi_rlast,
	input  wire logic              m_axi_rvalid,
	output logic                   m_axi_rready,
	input  wire logic [DATA_W-1:0] s_axis_tdata,
	input  wire logic              s_axis_tlast,
	input  wire logic              s_axis_tvalid,
	output logic                   s_axis_tready,
	output logic [DATA_W-1:0]      m_axis_tdata,
	output logic                   m_axis_tlast,
	output logic                   m_axis_tvalid,
	input  wire logic              m_axis_tready
);
	import aks_pkg::*;

	localparam logic [31:0] STEP = 32'(DATA_W / 8);
	localparam logic [2:0]  SIZE = 3'($clog2(DATA_W / 8));

	aks_ctrl_t        ctrl;
	aks_stat_t        stat;
	aks_state_t       state_reg, state_next;
	logic [31:0]      addr_reg, addr_next;
	logic [15:0]      left_reg, left_next;
	logic             pend_reg;
	logic [31:0]      pend_base_reg;
	logic [15:0]      pend_len_reg;
	logic             done_reg;
	logic             out_valid_reg;
	logic [DATA_W-1:0] out_data_reg;
	logic             out_last_reg;
	logic             sec_up_reg;
	logic [2:0]       sec_sync_reg;
	logic             sec_alive_reg;
	logic             is_free, is_pipe;
	logic             busy, ready_w, accept, zero_req;
	logic             start_now, start_pend;
	logic             slot_free, beat, last_word, finish, in_beat;
	logic             out_load;

	aks_lite_slave u_regs (
		.clk           (kernel_primary_clock),
		.nrst          (kernel_primary_reset_low),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.ctrl          (ctrl),
		.stat          (stat)
	);

	assign is_free = (MODE == AKS_MODE_FREE);
	assign is_pipe = (MODE == AKS_MODE_PIPE);
	assign busy    = (state_reg != AKS_ST_IDLE);
	assign ready_w = is_pipe ? !pend_reg : (!busy && !pend_reg);
	assign accept     = ctrl.start && !is_free && ready_w;
	assign zero_req   = accept && (ctrl.len == 16'h0000);
	assign start_now  = accept && !zero_req && !busy;
	assign start_pend = accept && !zero_req && busy;

	assign slot_free = !out_valid_reg || m_axis_tready;
	assign beat      = (state_reg == AKS_ST_DATA) && m_axi_rvalid &&
		m_axi_rready;
	assign last_word = (left_reg == 16'h0001);
	assign finish    = beat && last_word;
	assign s_axis_tready = is_free && slot_free;
	assign in_beat       = s_axis_tvalid && s_axis_tready;
	assign out_load      = beat || in_beat;

	assign m_axi_araddr  = addr_reg;
	assign m_axi_arlen   = AKS_ARLEN_ONE;
	assign m_axi_arsize  = SIZE;
	assign m_axi_arburst = AKS_BURST_INCR;
	assign m_axi_arvalid = (state_reg == AKS_ST_ADDR) && !is_free;
	assign m_axi_rready  = (state_reg == AKS_ST_DATA) && slot_free;

	always_comb begin
		state_next = state_reg;
		addr_next  = addr_reg;
		left_next  = left_reg;
		case (state_reg)
			AKS_ST_IDLE: begin
				if (pend_reg) begin
					state_next = AKS_ST_ADDR;
					addr_next  = pend_base_reg;
					left_next  = pend_len_reg;
				end else if (start_now) begin
					state_next = AKS_ST_ADDR;
					addr_next  = ctrl.base;
					left_next  = ctrl.len;
				end
			end
			AKS_ST_ADDR: begin
				if (m_axi_arready) begin
					state_next = AKS_ST_DATA;
				end
			end
			AKS_ST_DATA: begin
				if (beat) begin
					state_next = last_word ? AKS_ST_IDLE : AKS_ST_ADDR;
					addr_next  = addr_reg + STEP;
					left_next  = left_reg - 16'h0001;
				end
			end
			default: begin
				state_next = AKS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge kernel_primary_clock) begin
		if (!kernel_primary_reset_low) begin
			state_reg <= AKS_ST_IDLE;
			addr_reg  <= AKS_BASE_RST;
			left_reg  <= AKS_LEN_RST;
		end else begin
			state_reg <= state_next;
			addr_reg  <= addr_next;
			left_reg  <= left_next;
		end
	end

	always_ff @(posedge kernel_primary_clock) begin
		if (!kernel_primary_reset_low) begin
			pend_reg      <= 1'b0;
			pend_base_reg <= AKS_BASE_RST;
			pend_len_reg  <= AKS_LEN_RST;
		end else if (start_pend) begin
			pend_reg      <= 1'b1;
			pend_base_reg <= ctrl.base;
			pend_len_reg  <= ctrl.len;
		end else if (state_reg == AKS_ST_IDLE) begin
			pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge kernel_primary_clock) begin
		if (!kernel_primary_reset_low) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= finish || zero_req || (done_reg && !ctrl.ack);
		end
	end

	// Output stage holds until taken, so memory reads stall behind it
	always_ff @(posedge kernel_primary_clock) begin
		if (!kernel_primary_reset_low) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
			out_last_reg  <= 1'b0;
		end else if (out_load) begin
			out_valid_reg <= 1'b1;
			out_data_reg  <= beat ? m_axi_rdata : s_axis_tdata;
			out_last_reg  <= beat ? last_word : s_axis_tlast;
		end else if (m_axis_tready) begin
			out_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge kernel_secondary_clock) begin
		if (!kernel_secondary_reset_low) begin
			sec_up_reg <= 1'b0;
		end else begin
			sec_up_reg <= 1'b1;
		end
	end

	// Level crosses over three stages, accepted once the last two agree
	always_ff @(posedge kernel_primary_clock) begin
		if (!kernel_primary_reset_low) begin
			sec_sync_reg  <= AKS_SYNC_RST;
			sec_alive_reg <= 1'b0;
		end else begin
			sec_sync_reg <= {sec_sync_reg[1:0], sec_up_reg};
			if (sec_sync_reg[1] == sec_sync_reg[2]) begin
				sec_alive_reg <= sec_sync_reg[2];
			end
		end
	end

	assign stat = '{mode: MODE, sec_alive: sec_alive_reg,
		ready: is_free ? s_axis_tready : ready_w, busy: busy,
		done: done_reg};
	assign m_axis_tvalid = out_valid_reg;
	assign m_axis_tdata  = out_data_reg;
	assign m_axis_tlast  = out_last_reg;

	property p_seq_refuse;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		(MODE == AKS_MODE_SEQ) && busy && ctrl.start |=> !pend_reg;
	endproperty
	a_seq_refuse: assert property (p_seq_refuse)
		else $error("sequential kernel queued a start while busy");

	property p_pipe_queue;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		is_pipe && busy && !pend_reg && ctrl.start && ctrl.len != 16'h0000
		|=> pend_reg && pend_base_reg == $past(ctrl.base);
	endproperty
	a_pipe_queue: assert property (p_pipe_queue)
		else $error("pipelined start was not queued");

	property p_done_cause;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		$rose(done_reg) |-> $past(finish) || $past(zero_req);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done raised without task end");

	property p_done_hold;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		done_reg && !ctrl.ack |=> done_reg;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("done cleared without acknowledge");

	property p_free_no_master;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		is_free |-> !m_axi_arvalid && !m_axi_rready;
	endproperty
	a_free_no_master: assert property (p_free_no_master)
		else $error("free-running kernel used the memory master");

	property p_free_pass;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		is_free && s_axis_tvalid && !out_valid_reg
		|=> m_axis_tvalid && m_axis_tdata == $past(s_axis_tdata)
		&& m_axis_tlast == $past(s_axis_tlast);
	endproperty
	a_free_pass: assert property (p_free_pass)
		else $error("free-running beat or last flag lost");

	property p_start_base;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		start_now && !pend_reg
		|=> m_axi_arvalid && m_axi_araddr == $past(ctrl.base);
	endproperty
	a_start_base: assert property (p_start_base)
		else $error("first read not at host base address");

	property p_addr_step;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		beat && !last_word |=> m_axi_arvalid
		&& m_axi_araddr == $past(m_axi_araddr) + STEP;
	endproperty
	a_addr_step: assert property (p_addr_step)
		else $error("next read address not one word on");

	property p_out_hold;
		@(posedge kernel_primary_clock) disable iff (!kernel_primary_reset_low)
		m_axis_tvalid && !m_axis_tready
		|=> m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tlast);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("stream beat changed while stalled");

	c_seq_done: cover property (@(posedge kernel_primary_clock)
		finish && (MODE == AKS_MODE_SEQ));
	c_pipe_overlap: cover property (@(posedge kernel_primary_clock)
		start_pend);
	c_last_out: cover property (@(posedge kernel_primary_clock)
		m_axis_tvalid && m_axis_tready && m_axis_tlast);

endmodule // aks_kernel

// ==== verification/aks_mem_model.sv ====
// Purpose: global memory answering single-beat reads of the kernel
// Assumes: one read outstanding at a time, data derived from address
// Notes:   slow adds wait states before the address is accepted
`timescale 1ns/1ps
module aks_mem_model #(
	parameter logic [31:0] KEY = 32'h5a5a_5a5a
) (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic             rlast,
	output logic             rvalid,
	input  wire logic        rready
);
	logic [1:0] wait_reg;

	initial begin
		arready = 1'b0;
		rvalid = 1'b0;
		rlast = 1'b0;
		rdata = 32'h0000_0000;
		wait_reg = 2'h0;
	end

	always @(posedge clk) begin
		// Idle data keeps changing so a stale word never passes as valid
		if (!rvalid || rready)
			rdata <= ~rdata;
		if (rvalid && rready) begin
			rvalid <= 1'b0;
			rlast <= 1'b0;
		end
		if (arvalid && arready) begin
			arready <= 1'b0;
			wait_reg <= 2'h0;
			rvalid <= 1'b1;
			rlast <= 1'b1;
			rdata <= araddr ^ KEY;
		end else if (arvalid && !rvalid) begin
			arready <= (wait_reg >= {slow, slow});
			wait_reg <= wait_reg + 2'h1;
		end
	end
endmodule // aks_mem_model

// ==== verification/tb_accel_kernel_interface_shell.sv ====
// Purpose: self-checking bench of the kernel shell in all three modes
// Assumes: memory model answers reads, host side driven by tasks
// Notes:   stream beats are gathered by a monitor into queues
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
	bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_accel_kernel_interface_shell;
	import aks_pkg::*;
	localparam logic [31:0] KEY = 32'h5a5a_5a5a;
	logic sys_clk = 1'b0, clk2 = 1'b0, nrst = 1'b0, nrst2 = 1'b0;
	logic slow = 1'b0;
	int bad_count = 0, n_compared = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, m_axis_tready = 1;
	logic [31:0] s_axis_tdata = 0, s_axi_rdata, m_axi_araddr;
	logic [31:0] m_axi_rdata, m_axis_tdata;
	logic s_axis_tlast = 0, s_axis_tvalid = 0, s_axis_tready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, m_axi_arvalid, m_axi_arready, m_axi_rlast;
	logic m_axi_rvalid, m_axi_rready, m_axis_tlast, m_axis_tvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, m_axi_arburst;
	logic [7:0] m_axi_arlen;
	logic [2:0] m_axi_arsize;
	logic [31:0] beat_q[$];
	logic last_q[$];

	always #12.5 sys_clk = ~sys_clk;
	always #9 clk2 = ~clk2;

	aks_kernel #(.MODE(AKS_MODE_SEQ), .DATA_W(32)) dut (
		.kernel_primary_clock(sys_clk), .kernel_primary_reset_low(nrst),
		.kernel_secondary_clock(clk2), .kernel_secondary_reset_low(nrst2),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .m_axi_araddr, .m_axi_arlen, .m_axi_arsize,
		.m_axi_arburst, .m_axi_arvalid, .m_axi_arready, .m_axi_rdata,
		.m_axi_rresp(AKS_RESP_OKAY), .m_axi_rlast, .m_axi_rvalid,
		.m_axi_rready, .s_axis_tdata, .s_axis_tlast, .s_axis_tvalid,
		.s_axis_tready, .m_axis_tdata, .m_axis_tlast, .m_axis_tvalid,
		.m_axis_tready);

	aks_mem_model #(.KEY(KEY)) mem (.clk(sys_clk), .slow(slow),
		.araddr(m_axi_araddr), .arvalid(m_axi_arvalid),
		.arready(m_axi_arready), .rdata(m_axi_rdata), .rlast(m_axi_rlast),
		.rvalid(m_axi_rvalid), .rready(m_axi_rready));

	logic [31:0] p_araddr, p_rdata, f_tdata;
	logic p_arvalid, p_arready, p_rlast, p_rvalid, p_rready, p_tvalid;
	logic f_tlast, f_tvalid, f_tready, f_arvalid, f_rready;
	int p_beats = 0;

	// Pipelined twin shares the host side and queues a start while busy
	aks_kernel #(.MODE(AKS_MODE_PIPE), .DATA_W(32)) dut_pipe (
		.kernel_primary_clock(sys_clk), .kernel_primary_reset_low(nrst),
		.kernel_secondary_clock(clk2), .kernel_secondary_reset_low(nrst2),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready, .m_axi_araddr(p_araddr),
		.m_axi_arlen(), .m_axi_arsize(), .m_axi_arburst(),
		.m_axi_arvalid(p_arvalid), .m_axi_arready(p_arready),
		.m_axi_rdata(p_rdata), .m_axi_rresp(AKS_RESP_OKAY),
		.m_axi_rlast(p_rlast), .m_axi_rvalid(p_rvalid),
		.m_axi_rready(p_rready), .s_axis_tdata, .s_axis_tlast,
		.s_axis_tvalid, .s_axis_tready(), .m_axis_tdata(),
		.m_axis_tlast(), .m_axis_tvalid(p_tvalid), .m_axis_tready);

	aks_mem_model #(.KEY(KEY)) mem_pipe (.clk(sys_clk), .slow(slow),
		.araddr(p_araddr), .arvalid(p_arvalid), .arready(p_arready),
		.rdata(p_rdata), .rlast(p_rlast), .rvalid(p_rvalid),
		.rready(p_rready));

	// Free-running twin sees the host starts too and must ignore them
	aks_kernel #(.MODE(AKS_MODE_FREE), .DATA_W(32)) dut_free (
		.kernel_primary_clock(sys_clk), .kernel_primary_reset_low(nrst),
		.kernel_secondary_clock(clk2), .kernel_secondary_reset_low(nrst2),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready(),
		.s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready, .m_axi_araddr(), .m_axi_arlen(),
		.m_axi_arsize(), .m_axi_arburst(), .m_axi_arvalid(f_arvalid),
		.m_axi_arready(1'b0), .m_axi_rdata(32'h0000_0000),
		.m_axi_rresp(AKS_RESP_OKAY), .m_axi_rlast(1'b0),
		.m_axi_rvalid(1'b0), .m_axi_rready(f_rready), .s_axis_tdata,
		.s_axis_tlast, .s_axis_tvalid, .s_axis_tready(f_tready),
		.m_axis_tdata(f_tdata), .m_axis_tlast(f_tlast),
		.m_axis_tvalid(f_tvalid), .m_axis_tready);

	always @(negedge sys_clk) begin
		if (m_axis_tvalid === 1'b1 && m_axis_tready === 1'b1) begin
			beat_q.push_back(m_axis_tdata);
			last_q.push_back(m_axis_tlast);
		end
		if (p_tvalid === 1'b1 && m_axis_tready === 1'b1)
			p_beats++;
	end

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic bound(input bit hit);
		if (hit) begin
			bad_count++;
			$display("Error at %0t: wait ran out", $time);
			conclude();
		end
	endtask

	task automatic await(ref logic s);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (s !== 1'b1 && n < 64) begin
			@(negedge sys_clk);
			n++;
		end
		bound(n >= 64);
	endtask

	task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
		s_axi_awaddr = a;
		s_axi_wdata = d;
		s_axi_awvalid = 1'b1;
		s_axi_wvalid = 1'b1;
		await(s_axi_awready);
		step();
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_awaddr = ~a;
		s_axi_wdata = ~d;
		s_axi_bready = 1'b1;
		await(s_axi_bvalid);
		`CHK(s_axi_bresp, er)
		step();
		s_axi_bready = 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
		s_axi_araddr = a;
		s_axi_arvalid = 1'b1;
		await(s_axi_arready);
		step();
		s_axi_arvalid = 1'b0;
		s_axi_araddr = ~a;
		s_axi_rready = 1'b1;
		await(s_axi_rvalid);
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
		step();
		s_axi_rready = 1'b0;
	endtask

	task automatic job(input logic [31:0] base, input logic [15:0] len,
		input bit dbl);
		int n;
		int want;
		want = dbl ? 2 * len : len;
		p_beats = 0;
		beat_q.delete();
		last_q.delete();
		wr(AKS_OFF_BASE, base, AKS_RESP_OKAY);
		wr(AKS_OFF_LEN, {16'h0000, len}, AKS_RESP_OKAY);
		wr(AKS_OFF_CTRL, 32'h0000_0001, AKS_RESP_OKAY);
		if (dbl) begin
			m_axis_tready = 1'b0;
			rd(AKS_OFF_STATUS, 32'h0000_000a, AKS_RESP_OKAY);
			wr(AKS_OFF_CTRL, 32'h0000_0001, AKS_RESP_OKAY);
			repeat (6) step();
			m_axis_tready = 1'b1;
		end
		n = 0;
		while ((beat_q.size() < len || p_beats < want) && n < 400) begin
			step();
			n++;
		end
		bound(n >= 400);
		repeat (12) step();
		`CHK(beat_q.size(), int'(len))
		`CHK(p_beats, want)
		`CHK(m_axi_arlen, AKS_ARLEN_ONE)
		`CHK(m_axi_arsize, 3'h2)
		`CHK(m_axi_arburst, AKS_BURST_INCR)
		foreach (beat_q[i]) begin
			`CHK(beat_q[i], (base + 32'(4 * i)) ^ KEY)
			`CHK(last_q[i], 1'(i == len - 1))
		end
		rd(AKS_OFF_STATUS, 32'h0000_000d, AKS_RESP_OKAY);
		wr(AKS_OFF_STATUS, 32'h0000_0001, AKS_RESP_OKAY);
		rd(AKS_OFF_STATUS, 32'h0000_000c, AKS_RESP_OKAY);
	endtask

	task automatic t_reset();
		`CHK(s_axi_bvalid, 1'b0)
		`CHK(m_axi_arvalid, 1'b0)
		`CHK(m_axis_tvalid, 1'b0)
		rd(AKS_OFF_STATUS, 32'h0000_0004, AKS_RESP_OKAY);
		rd(AKS_OFF_BASE, AKS_BASE_RST, AKS_RESP_OKAY);
		rd(AKS_OFF_LEN, 32'h0000_0000, AKS_RESP_OKAY);
		rd(32'h0000_0010, 32'h0000_0000, AKS_RESP_SLVERR);
		wr(32'h0000_0010, 32'h0000_0001, AKS_RESP_SLVERR);
		wr(AKS_OFF_CTRL, 32'h0000_0000, AKS_RESP_OKAY);
		`CHK(m_axi_arvalid, 1'b0)
		@(posedge clk2);
		#1 nrst2 = 1'b1;
		repeat (8) step();
		rd(AKS_OFF_STATUS, 32'h0000_000c, AKS_RESP_OKAY);
		$display("test reset done");
	endtask

	task automatic t_seq();
		job(32'h0000_1000, 16'h0003, 1'b0);
		slow = 1'b1;
		job(32'h0000_2ff8, 16'h0002, 1'b1);
		slow = 1'b0;
		job(32'h0000_3000, 16'h0000, 1'b0);
		$display("test sequential done");
	endtask

	task automatic t_stream();
		s_axis_tdata = 32'h1234_5678;
		s_axis_tlast = 1'b1;
		s_axis_tvalid = 1'b1;
		repeat (3) begin
			step();
			`CHK(s_axis_tready, 1'b0)
			`CHK(m_axis_tvalid, 1'b0)
		end
		s_axis_tvalid = 1'b0;
		$display("test stream done");
	endtask

	// free twin takes data with no start, paced by the sink
	task automatic t_free();
		step();
		s_axis_tdata = 32'hc001_0000;
		s_axis_tlast = 1'b0;
		s_axis_tvalid = 1'b1;
		m_axis_tready = 1'b0;
		step();
		`CHK(f_tvalid, 1'b1)
		`CHK(f_tdata, 32'hc001_0000)
		`CHK(f_tready, 1'b0)
		s_axis_tdata = 32'hc001_0001;
		s_axis_tlast = 1'b1;
		step();
		`CHK(f_tdata, 32'hc001_0000)
		m_axis_tready = 1'b1;
		step();
		`CHK(f_tdata, 32'hc001_0001)
		`CHK(f_tlast, 1'b1)
		s_axis_tvalid = 1'b0;
		step();
		`CHK(f_tvalid, 1'b0)
		`CHK(f_arvalid, 1'b0)
		`CHK(f_rready, 1'b0)
		$display("test free done");
	endtask

	initial begin
		// reset low, released after three edges
		repeat (3) @(posedge sys_clk);
		#1 nrst = 1'b1;
		t_reset();
		t_seq();
		t_stream();
		t_free();
		conclude();
	end
endmodule // tb_accel_kernel_interface_shell
